// file: hdl/cirst_defines.vh
// Constants for the infrared port status and baud divisor block.
//
// Behaviour
// - Divisor low byte, index 5 with bank select set, read/write, resets 00h.
// - Divisor high byte, index 6 with bank select set, read/write, resets 00h.
// - Bit rate equals 115200 divided by the sixteen-bit divisor.
// - Bank clear, index 5 reads transmit byte count in bits 5-0.
// - Bank clear, index 6 reads receive byte count; bit 6 reads zero.
// - Receive status bit 7 is a read-only time-out flag, reset zero.
// - Time-out needs FIFO non-empty, receiver idle and no host read, each 64 ms.
// - Ident bits 2-1 code none, transmit low, receive stored, overrun.
// - Ident bit 0 shows a pending interrupt, resets to one.
`ifndef CIRST_DEFINES_VH
`define CIRST_DEFINES_VH

// Register indices; the byte address is four times the index.
`define CIRST_IDX_BANK 10'h003
`define CIRST_IDX_DIV_LO 10'h005
`define CIRST_IDX_DIV_HI 10'h006
`define CIRST_IDX_IDENT 10'h007
`define CIRST_IDX_INT_STAT 10'h008
`define CIRST_IDX_INT_CLR 10'h009
`define CIRST_IDX_INT_EN 10'h00A

// Field positions.
`define CIRST_BANK_BIT 7
`define CIRST_TO_BIT 7
`define CIRST_EV_TX_LOW 0
`define CIRST_EV_RX_STORED 1
`define CIRST_EV_OVERRUN 2
`define CIRST_EV_TIMEOUT 3
`define CIRST_NUM_EV 4

// Reset values.
`define CIRST_DIV_RST 8'h00
`define CIRST_IDENT_RST 8'h01
`define CIRST_INT_RST 4'h0

// Interrupt source codes.
`define CIRST_CODE_NONE 2'h0
`define CIRST_CODE_TX_LOW 2'h1
`define CIRST_CODE_RX_STORED 2'h2
`define CIRST_CODE_OVERRUN 2'h3

// Timing.
`define CIRST_CLK_HZ 125000000
`define CIRST_REF_HZ 115200
`define CIRST_TIMEOUT_MS 64
`define CIRST_TIMEOUT_CYC (`CIRST_TIMEOUT_MS * (`CIRST_CLK_HZ / 1000))

`endif

// file: hdl/cirst_baud_gen.v
// Baud tick generator dividing a 115200 Hz reference by the divisor.
`timescale 1ns/10ps
`default_nettype none
`include "cirst_defines.vh"

module cirst_baud_gen #(
  parameter CLK_HZ = `CIRST_CLK_HZ,
  parameter REF_HZ = `CIRST_REF_HZ
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Divisor from the register file.
  input wire [15:0] divisor,
  // One-cycle tick at the bit rate.
  output reg baud_tick
);

  localparam [26:0] ACC_MOD = CLK_HZ[26:0];
  localparam [26:0] ACC_STEP = REF_HZ[26:0];

  reg [26:0] acc_reg;
  reg ref_tick_reg;
  reg [15:0] cnt_reg;

  // Fractional accumulator makes a 115200 Hz reference tick from pclk.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 27'h0000000;
      ref_tick_reg <= 1'b0;
    end else if (acc_reg >= ACC_MOD - ACC_STEP) begin
      acc_reg <= acc_reg + ACC_STEP - ACC_MOD;
      ref_tick_reg <= 1'b1;
    end else begin
      acc_reg <= acc_reg + ACC_STEP;
      ref_tick_reg <= 1'b0;
    end
  end

  // Reference ticks are counted to the divisor; a zero divisor stops the rate.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= 1'b0;
      if (divisor == 16'h0000) begin
        cnt_reg <= 16'h0000;
      end else if (ref_tick_reg) begin
        if (cnt_reg >= divisor - 16'h0001) begin
          cnt_reg <= 16'h0000;
          baud_tick <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end
    end
  end

endmodule // cirst_baud_gen
`default_nettype wire

// file: hdl/cirst_top.v
// APB register block for infrared port FIFO status, time-out, ident and divisor.
`timescale 1ns/10ps
`default_nettype none
`include "cirst_defines.vh"

module cirst_top #(
  parameter ADDR_W = 12,
  parameter TIMEOUT_CYCLES = `CIRST_TIMEOUT_CYC,
  parameter CNT_W = 24
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // FIFO side, same clock.
  input wire [5:0] tx_fifo_byte_count,
  input wire [5:0] rx_fifo_byte_count,
  input wire rx_byte_read,
  input wire tx_low_level,
  input wire rx_data_stored,
  input wire rx_overrun,
  // Receiver activity from the transceiver pin side.
  input wire receiver_activity,
  // Rate and interrupt outputs.
  output reg [15:0] baud_divisor,
  output wire baud_tick,
  output reg rx_fifo_timeout_flag,
  output reg irq
);

  localparam [CNT_W-1:0] TO_LIMIT = TIMEOUT_CYCLES[CNT_W-1:0];

  // Register address decode shared by read and write paths.
  // Misaligned addresses never hit, so they end in an error response.
  function hit;
    input [ADDR_W-1:0] addr;
    input [9:0] idx;
    begin
      hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
    end
  endfunction

  // Register file, event and timer state.
  reg divisor_bank_select;
  reg [7:0] baud_divisor_low;
  reg [7:0] baud_divisor_high;
  reg [7:0] interrupt_source_ident;
  reg [`CIRST_NUM_EV-1:0] int_stat_reg;
  reg [`CIRST_NUM_EV-1:0] int_en_reg;
  reg [`CIRST_NUM_EV-1:0] int_clr;
  reg [`CIRST_NUM_EV-1:0] ev_prev_reg;
  reg [2:0] act_sync_reg;
  reg act_stable_reg;
  reg [CNT_W-1:0] nonempty_cnt_reg;
  reg [CNT_W-1:0] idle_cnt_reg;
  reg [CNT_W-1:0] since_read_cnt_reg;
  reg [31:0] rd_next;
  reg err_next;
  // Bus decode and combinational results.
  wire wr_en;
  wire setup;
  wire timeout_next;
  wire [`CIRST_NUM_EV-1:0] ev_level;
  wire [1:0] interrupt_source_code;
  wire interrupt_pending_flag;

  // Bus phase decode.
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  // Read multiplexer, bank dependent at indices 5 and 6.
  // With the bank bit clear the divisor bytes are hidden behind the FIFO status,
  // so software must set the bank bit before it loads a new rate.
  always @* begin
    rd_next = 32'h00000000;
    err_next = 1'b0;
    if (hit(paddr, `CIRST_IDX_BANK)) begin
      rd_next[`CIRST_BANK_BIT] = divisor_bank_select;
    end else if (hit(paddr, `CIRST_IDX_DIV_LO)) begin
      if (divisor_bank_select) begin
        rd_next[7:0] = baud_divisor_low;
      end else begin
        rd_next[5:0] = tx_fifo_byte_count;
      end
    end else if (hit(paddr, `CIRST_IDX_DIV_HI)) begin
      if (divisor_bank_select) begin
        rd_next[7:0] = baud_divisor_high;
      end else begin
        rd_next[5:0] = rx_fifo_byte_count;
        rd_next[`CIRST_TO_BIT] = rx_fifo_timeout_flag;
      end
    end else if (hit(paddr, `CIRST_IDX_IDENT)) begin
      rd_next[7:0] = interrupt_source_ident;
    end else if (hit(paddr, `CIRST_IDX_INT_STAT)) begin
      rd_next[`CIRST_NUM_EV-1:0] = int_stat_reg;
    end else if (hit(paddr, `CIRST_IDX_INT_CLR)) begin
      rd_next = 32'h00000000;
    end else if (hit(paddr, `CIRST_IDX_INT_EN)) begin
      rd_next[`CIRST_NUM_EV-1:0] = int_en_reg;
    end else begin
      err_next = 1'b1;
    end
  end

  // Zero-wait APB answer: data and ready are captured in the setup cycle.
  // Capturing in the setup cycle keeps prdata a flop output and still answers
  // in the first access cycle; read data then stands until psel falls.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && err_next;
      if (setup && !pwrite) begin
        prdata <= rd_next;
      end else if (!psel) begin
        prdata <= 32'h00000000;
      end
    end
  end

  // Writable registers; read-only locations ignore writes.
  // The bank bit gates the divisor writes, so a write at index 5 or 6 with the bank
  // clear lands on a status location and is dropped without an error.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_bank_select <= 1'b0;
      baud_divisor_low <= `CIRST_DIV_RST;
      baud_divisor_high <= `CIRST_DIV_RST;
      int_en_reg <= `CIRST_INT_RST;
    end else if (wr_en) begin
      if (hit(paddr, `CIRST_IDX_BANK)) begin
        divisor_bank_select <= pwdata[`CIRST_BANK_BIT];
      end
      if (hit(paddr, `CIRST_IDX_DIV_LO) && divisor_bank_select) begin
        baud_divisor_low <= pwdata[7:0];
      end
      if (hit(paddr, `CIRST_IDX_DIV_HI) && divisor_bank_select) begin
        baud_divisor_high <= pwdata[7:0];
      end
      if (hit(paddr, `CIRST_IDX_INT_EN)) begin
        int_en_reg <= pwdata[`CIRST_NUM_EV-1:0];
      end
    end
  end

  // Clear strobes from a write to the clear register.
  // The strobes last one cycle and meet the set path in the status logic below.
  always @* begin
    int_clr = `CIRST_INT_RST;
    if (wr_en && hit(paddr, `CIRST_IDX_INT_CLR)) begin
      int_clr = pwdata[`CIRST_NUM_EV-1:0];
    end
  end

  // Divisor output for the rate logic.
  // Between the two byte writes the rate runs on one new and one old byte.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_divisor <= {`CIRST_DIV_RST, `CIRST_DIV_RST};
    end else begin
      baud_divisor <= {baud_divisor_high, baud_divisor_low};
    end
  end

  // Bit-rate tick from the 115200 reference.
  // A zero divisor stops the tick rather than dividing by zero.
  cirst_baud_gen #(
    .CLK_HZ(`CIRST_CLK_HZ),
    .REF_HZ(`CIRST_REF_HZ)
  ) u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(baud_divisor),
    .baud_tick(baud_tick)
  );

  // Activity pin passes three stages; a change counts once stages two and three agree.
  // The first stage may go metastable; only the second stage reads it.
  // The agreement test also drops single-cycle glitches on the line.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sync_reg <= 3'h0;
      act_stable_reg <= 1'b0;
    end else begin
      act_sync_reg <= {act_sync_reg[1:0], receiver_activity};
      if (act_sync_reg[1] == act_sync_reg[2]) begin
        act_stable_reg <= act_sync_reg[2];
      end
    end
  end

  // Three saturating timers for the time-out conditions.
  // Each timer clears on its own event and stops at or one count past the limit, so it
  // never wraps however long the line stays idle.
  // The non-empty timer stops at the limit, the other two one count beyond it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nonempty_cnt_reg <= {CNT_W{1'b0}};
      idle_cnt_reg <= {CNT_W{1'b0}};
      since_read_cnt_reg <= {CNT_W{1'b0}};
    end else begin
      if (rx_fifo_byte_count == 6'h00) begin
        nonempty_cnt_reg <= {CNT_W{1'b0}};
      end else if (nonempty_cnt_reg < TO_LIMIT) begin
        nonempty_cnt_reg <= nonempty_cnt_reg + 1'b1;
      end
      if (act_stable_reg) begin
        idle_cnt_reg <= {CNT_W{1'b0}};
      end else if (idle_cnt_reg <= TO_LIMIT) begin
        idle_cnt_reg <= idle_cnt_reg + 1'b1;
      end
      if (rx_byte_read) begin
        since_read_cnt_reg <= {CNT_W{1'b0}};
      end else if (since_read_cnt_reg <= TO_LIMIT) begin
        since_read_cnt_reg <= since_read_cnt_reg + 1'b1;
      end
    end
  end

  // Non-empty needs at least the limit; the other two need more than it.
  // A read in the same cycle vetoes the flag, so a read always drops it at the next edge.
  assign timeout_next = (nonempty_cnt_reg >= TO_LIMIT) && (idle_cnt_reg > TO_LIMIT)
    && (since_read_cnt_reg > TO_LIMIT) && !rx_byte_read;

  // Time-out flag follows its conditions and drops when any fails.
  // It has no clear of its own; software drops it by reading a byte.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fifo_timeout_flag <= 1'b0;
    end else begin
      rx_fifo_timeout_flag <= timeout_next;
    end
  end

  // Source code with overrun first, then receive stored, then transmit low.
  // The code follows the raw source levels, not the enable register, so software
  // can poll the ident register with interrupts masked.
  assign interrupt_source_code = rx_overrun ? `CIRST_CODE_OVERRUN :
    rx_data_stored ? `CIRST_CODE_RX_STORED :
    tx_low_level ? `CIRST_CODE_TX_LOW : `CIRST_CODE_NONE;
  assign interrupt_pending_flag = (interrupt_source_code != `CIRST_CODE_NONE);

  // Ident register; reserved bits stay zero.
  // It resets to 01h and is refreshed from the sources at every edge after that.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_source_ident <= `CIRST_IDENT_RST;
    end else begin
      interrupt_source_ident <= {5'h00, interrupt_source_code, interrupt_pending_flag};
    end
  end

  // Event levels that feed the sticky status bits.
  assign ev_level[`CIRST_EV_TX_LOW] = tx_low_level;
  assign ev_level[`CIRST_EV_RX_STORED] = rx_data_stored;
  assign ev_level[`CIRST_EV_OVERRUN] = rx_overrun;
  assign ev_level[`CIRST_EV_TIMEOUT] = rx_fifo_timeout_flag;

  // Sticky status per event, set on a rising edge; set wins over clear.
  // Detecting edges keeps a level that stays high from setting the bit again
  // right after software has cleared it.
  genvar gi;
  generate
    for (gi = 0; gi < `CIRST_NUM_EV; gi = gi + 1) begin : g_ev
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ev_prev_reg[gi] <= 1'b0;
          int_stat_reg[gi] <= 1'b0;
        end else begin
          ev_prev_reg[gi] <= ev_level[gi];
          if (ev_level[gi] && !ev_prev_reg[gi]) begin
            int_stat_reg[gi] <= 1'b1;
          end else if (int_clr[gi]) begin
            int_stat_reg[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Level interrupt while any enabled status bit is set.
  // Registering it keeps the output a flop, at the cost of one cycle of delay.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_reg & int_en_reg);
    end
  end

endmodule // cirst_top
`default_nettype wire

// file: bench/cirst_props.sv
// Assertion checker for the infrared port status and divisor block.
`timescale 1ns/10ps
`default_nettype none
module cirst_props #(
  parameter ADDR_W = 12
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Receive side and rate outputs.
  input wire logic [5:0] rx_fifo_byte_count,
  input wire logic rx_byte_read,
  input wire logic receiver_activity,
  input wire logic [15:0] baud_divisor,
  input wire logic baud_tick,
  input wire logic rx_fifo_timeout_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A setup phase is always answered in the following cycle.
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("setup phase not answered");
  // Indices above the map end with an error response.
  property p_unmap; pready && paddr[ADDR_W-1:2] > 10 |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access without error");
  // Ticks are far apart at any divisor, since the reference is far below the clock.
  property p_gap; baud_tick |=> !baud_tick [*8]; endproperty
  a_gap: assert property (p_gap) else $error("baud ticks too close");
  // The divisor moves only after a bus write.
  property p_div; $changed(baud_divisor) |-> $past(psel, 2) && $past(penable, 2) && $past(pwrite, 2); endproperty
  a_div: assert property (p_div) else $error("divisor changed without write");
  // The ident word has zero reserved bits and pending equals a nonzero code.
  property p_ident; pready && !pwrite && paddr[ADDR_W-1:2] == 7 |-> prdata[31:3] == 0 && prdata[0] == |prdata[2:1]; endproperty
  a_ident: assert property (p_ident) else $error("ident word malformed");
  // The flag only rises with a non-empty FIFO, an idle line and no recent read.
  property p_rise; $rose(rx_fifo_timeout_flag) |-> $past(rx_fifo_byte_count) != 0 && !$past(rx_byte_read) && !$past(receiver_activity, 8); endproperty
  a_rise: assert property (p_rise) else $error("time-out flag rose without cause");
  // A host read drops the flag at the next edge.
  property p_read; rx_byte_read |=> !rx_fifo_timeout_flag; endproperty
  a_read: assert property (p_read) else $error("time-out flag kept after read");
  // An empty FIFO drops the flag within two edges.
  property p_empty; rx_fifo_byte_count == 6'h00 |-> ##2 !rx_fifo_timeout_flag; endproperty
  a_empty: assert property (p_empty) else $error("time-out flag kept while empty");
  // Read data is cleared while the bus stays idle.
  property p_idle; !psel [*2] |-> prdata == 32'h00000000; endproperty
  a_idle: assert property (p_idle) else $error("read data not cleared when idle");
endmodule // cirst_props
bind cirst_top cirst_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_fifo_byte_count(rx_fifo_byte_count), .rx_byte_read(rx_byte_read), .receiver_activity(receiver_activity),
  .baud_divisor(baud_divisor), .baud_tick(baud_tick), .rx_fifo_timeout_flag(rx_fifo_timeout_flag));
`default_nettype wire

// file: bench/cirst_ir_model.sv
// Behavioural infrared transceiver that reports line activity.
`timescale 1ns/10ps
`default_nettype none
module cirst_ir_model #(
  parameter ACT_LEN = 10
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Start of a received pulse burst.
  input wire logic burst,
  // Activity level seen on the line.
  output logic receiver_activity
);
  int left;
  // A burst keeps the receiver busy, which restarts the idle time.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 0;
      receiver_activity <= 1'b0;
    end else begin
      left <= burst ? ACT_LEN : (left > 0 ? left - 1 : 0);
      receiver_activity <= burst || left > 1;
    end
  end
endmodule // cirst_ir_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the infrared port status and divisor block.
`timescale 1ns/10ps
`default_nettype none
`include "cirst_defines.vh"
module testbench;
  localparam int T = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_byte_read = 0, burst = 0;
  logic tx_low_level = 0, rx_data_stored = 0, rx_overrun = 0, receiver_activity, baud_tick, irq;
  logic pready, pslverr, rx_fifo_timeout_flag, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [5:0] tx_fifo_byte_count = 6'h00, rx_fifo_byte_count = 6'h00;
  logic [15:0] baud_divisor, dv;
  int error_cnt = 0, tests_run = 0, cyc = 0, t0, ep;

  cirst_top #(.TIMEOUT_CYCLES(T)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_fifo_byte_count(tx_fifo_byte_count), .rx_fifo_byte_count(rx_fifo_byte_count),
    .rx_byte_read(rx_byte_read), .tx_low_level(tx_low_level), .rx_data_stored(rx_data_stored),
    .rx_overrun(rx_overrun), .receiver_activity(receiver_activity), .baud_divisor(baud_divisor),
    .baud_tick(baud_tick), .rx_fifo_timeout_flag(rx_fifo_timeout_flag), .irq(irq));
  cirst_ir_model u_ir (.pclk(pclk), .presetn(presetn), .burst(burst), .receiver_activity(receiver_activity));

  // Clock and hang guard.
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      $display("[FAIL] %0t watchdog expired", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // One bus transfer; data and response are taken at the ready edge.
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      error_cnt++;
      $display("[FAIL] %0t bus answer missing", $time);
    end
  endtask

  task automatic rdc(input logic [9:0] i, input logic [7:0] e, input string m);
    apb(1'b0, i, 8'h00);
    chk(rd, {24'h000000, e}, m);
  endtask

  task automatic wtick();
    for (int k = 0; k < 9000 && baud_tick !== 1'b1; k++)
      @(posedge pclk);
    @(posedge pclk);
  endtask

  function automatic logic [7:0] exp_ident(input logic [2:0] s);
    logic [1:0] c;
    c = s[2] ? 2'h3 : s[1] ? 2'h2 : s[0] ? 2'h1 : 2'h0;
    return {5'h00, c, c != 2'h0};
  endfunction

  // Main sequence.
  initial begin
    void'($urandom(94779));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `CIRST_IDX_BANK, 8'h80);
    rdc(`CIRST_IDX_DIV_LO, 8'h00, "div lo reset");
    rdc(`CIRST_IDX_DIV_HI, 8'h00, "div hi reset");
    dv = 16'($urandom);
    apb(1'b1, `CIRST_IDX_DIV_LO, dv[7:0]);
    apb(1'b1, `CIRST_IDX_DIV_HI, dv[15:8]);
    rdc(`CIRST_IDX_DIV_LO, dv[7:0], "div lo");
    rdc(`CIRST_IDX_DIV_HI, dv[15:8], "div hi");
    chk({16'h0000, baud_divisor}, {16'h0000, dv}, "divisor out");
    dv = 16'($urandom_range(3, 1));
    apb(1'b1, `CIRST_IDX_DIV_HI, 8'h00);
    apb(1'b1, `CIRST_IDX_DIV_LO, dv[7:0]);
    wtick();
    wtick();
    t0 = int'($time);
    wtick();
    ep = 125000000 * int'(dv) / 115200;
    chk(32'((int'($time) - t0) / 8 > ep + 2 || (int'($time) - t0) / 8 + 2 < ep), 0, "tick period");
    // Bank clear: byte counts at their bounds and random, each read after a write at index 5; the divisor is not read back.
    apb(1'b1, `CIRST_IDX_BANK, 8'h00);
    for (int k = 0; k < 5; k++) begin
      tx_fifo_byte_count <= k == 1 ? 6'h3F : k == 0 ? 6'h00 : 6'($urandom);
      rx_fifo_byte_count <= k == 0 ? 6'h3F : k == 1 ? 6'h00 : 6'($urandom);
      apb(1'b1, `CIRST_IDX_DIV_LO, 8'hFF);
      rdc(`CIRST_IDX_DIV_LO, {2'b00, tx_fifo_byte_count}, "tx status");
      apb(1'b0, `CIRST_IDX_DIV_HI, 8'h00);
      chk(rd & 32'h0000007F, {26'h0, rx_fifo_byte_count}, "rx status");
    end
    rx_fifo_byte_count <= 6'h00;
    // Every combination of sources gives its code in priority order.
    for (int k = 0; k < 8; k++) begin
      {rx_overrun, rx_data_stored, tx_low_level} <= 3'(k);
      apb(1'b1, `CIRST_IDX_IDENT, 8'hFF);
      rdc(`CIRST_IDX_IDENT, exp_ident(3'(k)), "ident");
    end
    // Interrupt raise, mask and clear.
    {rx_overrun, rx_data_stored, tx_low_level} <= 3'b000;
    apb(1'b1, `CIRST_IDX_INT_CLR, 8'h0F);
    apb(1'b1, `CIRST_IDX_INT_EN, 8'h02);
    rdc(`CIRST_IDX_INT_STAT, 8'h00, "status cleared");
    rx_data_stored <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(irq, 1, "irq raised");
    rdc(`CIRST_IDX_INT_STAT, 8'h02, "status set");
    apb(1'b1, `CIRST_IDX_INT_EN, 8'h00);
    repeat (2) @(posedge pclk);
    chk(irq, 0, "irq masked");
    apb(1'b1, `CIRST_IDX_INT_EN, 8'h02);
    apb(1'b1, `CIRST_IDX_INT_CLR, 8'h02);
    repeat (2) @(posedge pclk);
    chk(irq, 0, "irq cleared");
    apb(1'b0, 10'h3FF, 8'h00);
    chk(err, 1, "unmapped error");
    // Receive time-out: set, read back, cleared by a read and by activity.
    rx_fifo_byte_count <= 6'h01;
    rx_byte_read <= 1'b1;
    @(posedge pclk);
    rx_byte_read <= 1'b0;
    repeat (T - 4) @(posedge pclk);
    chk(rx_fifo_timeout_flag, 0, "flag early");
    repeat (12) @(posedge pclk);
    chk(rx_fifo_timeout_flag, 1, "flag set");
    rdc(`CIRST_IDX_INT_STAT, 8'h08, "timeout event");
    rdc(`CIRST_IDX_DIV_HI, 8'h81, "flag in status");
    rx_byte_read <= 1'b1;
    @(posedge pclk);
    rx_byte_read <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(rx_fifo_timeout_flag, 0, "read clears");
    repeat (T + 8) @(posedge pclk);
    chk(rx_fifo_timeout_flag, 1, "flag back");
    burst <= 1'b1;
    @(posedge pclk);
    burst <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(rx_fifo_timeout_flag, 0, "activity clears");
    close_out();
  end
endmodule // testbench
`default_nettype wire
